// *** rtl/rtc_pkg.sv ***
// rtc_pkg: register map, field positions, reset values and timing counts
// of the real-time clock control, alarm and time-of-day block.
// assumes an AHB-Lite slave with 32-bit data, one aligned word per register.
package rtc_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam logic [7:0] OFS_RTC_CONTROL = 8'h00;
    localparam logic [7:0] OFS_ALARM_CONTROL = 8'h10;
    localparam logic [7:0] OFS_TIME_OF_DAY = 8'h20;

    // ----------------------------------------------------------------
    // rtc_control fields
    // ----------------------------------------------------------------
    localparam int CTL_ENABLE_BIT = 15;
    localparam int CTL_OUT_SEL_BIT = 7;
    localparam int CTL_RUNNING_BIT = 6;
    localparam int CTL_UNLOCK_BIT = 3;
    localparam int CTL_RIPPLE_BIT = 2;
    localparam int CTL_HALF_BIT = 1;
    localparam int CTL_OE_BIT = 0;

    // ----------------------------------------------------------------
    // alarm_control fields
    // ----------------------------------------------------------------
    localparam int ALM_ENABLE_BIT = 15;
    localparam int ALM_CHIME_BIT = 14;
    localparam int ALM_PIV_BIT = 13;
    localparam int ALM_SYNC_BIT = 12;
    localparam int ALM_MASK_LSB = 8;
    localparam int ALM_RPT_LSB = 0;
    localparam logic [7:0] RPT_WRAP = 8'hff;

    // ----------------------------------------------------------------
    // time_of_day_value digits, index 0 = second units .. 5 = hour tens
    // ----------------------------------------------------------------
    localparam int NUM_DIGITS = 6;
    localparam int DIG_LSB [NUM_DIGITS] = '{8, 12, 16, 20, 24, 28};
    localparam int DIG_W [NUM_DIGITS] = '{4, 3, 4, 3, 4, 2};
    localparam logic [3:0] DIG_MAX [NUM_DIGITS] =
        '{4'h9, 4'h5, 4'h9, 4'h5, 4'h9, 4'h2};
    localparam logic [3:0] HOUR_TENS_LAST = 4'h2;
    localparam logic [3:0] HOUR_UNITS_LAST = 4'h3;

    // ----------------------------------------------------------------
    // reset values and timing counts (in rtc ticks)
    // ----------------------------------------------------------------
    localparam logic [3:0] DIGIT_RST = 4'h0;
    localparam logic PIV_RST = 1'b0;
    localparam int RTC_TICKS_PER_SEC = 32768;
    localparam int SYNC_WINDOW_TICKS = 32;

    // alarm interval codes
    typedef enum logic [3:0] {
        AM_HALF_SEC, AM_SEC, AM_TEN_SEC, AM_MIN, AM_TEN_MIN,
        AM_HOUR, AM_DAY, AM_WEEK, AM_MONTH, AM_YEAR
    } alarm_mask_e;

endpackage

// *** rtl/rtc_digit_if.sv ***
// rtc_digit_if: control and value of one bcd digit counter.
// assumes the owner drives the ctrl side and one digit drives the other.
`timescale 1ns/1ps
interface rtc_digit_if;
    logic inc;
    logic clr;
    logic ld;
    logic [3:0] ld_val;
    logic [3:0] val;
    logic at_max;
    modport ctrl(output inc, output clr, output ld, output ld_val,
                 input val, input at_max);
    modport digit(input inc, input clr, input ld, input ld_val,
                  output val, output at_max);
endinterface

// *** rtl/rtc_bcd_digit.sv ***
// rtc_bcd_digit: one bcd digit of the time-of-day counter.
// assumes load, clear and increment are one-cycle strobes from the owner.
`timescale 1ns/1ps
module rtc_bcd_digit #(
    parameter logic [3:0] MAX = 4'h9
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // digit control
    rtc_digit_if.digit dig
);
    import rtc_pkg::*;

    logic [3:0] val_q;

    // load beats clear beats increment; out-of-range values wrap to zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            val_q <= DIGIT_RST;
        end else if (dig.ld) begin
            val_q <= dig.ld_val;
        end else if (dig.clr) begin
            val_q <= 4'h0;
        end else if (dig.inc) begin
            val_q <= (val_q >= MAX) ? 4'h0 : val_q + 4'h1;
        end
    end

    assign dig.val = val_q;
    assign dig.at_max = (val_q == MAX);

endmodule // rtc_bcd_digit

// *** rtl/rtc_alarm_time_regs.sv ***
// rtc_alarm_time_regs: control, alarm engine and time-of-day of the rtc,
// reached over ahb-lite.
// assumes rtc_tick is a one-cycle strobe per rtc clock, and that date
// comparison (weekday, day, month, leap year) is done by calendar logic.
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
module rtc_alarm_time_regs #(
    parameter int TICKS_PER_SEC = rtc_pkg::RTC_TICKS_PER_SEC,
    parameter int SYNC_TICKS = rtc_pkg::SYNC_WINDOW_TICKS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [rtc_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [rtc_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [rtc_pkg::DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // timebase and system unlock
    input wire logic rtc_tick,
    input wire logic sys_unlock,
    // alarm comparison inputs, alarm_time in time register layout
    input wire logic [rtc_pkg::DATA_W-1:0] alarm_time,
    input wire logic wday_match,
    input wire logic day_match,
    input wire logic month_match,
    input wire logic alarm_feb29,
    input wire logic leap_year,
    // output pin
    output logic rtc_out
);
    import rtc_pkg::*;

    localparam int CNT_W = $clog2(TICKS_PER_SEC);
    localparam logic [CNT_W-1:0] LAST_C = CNT_W'(TICKS_PER_SEC - 1);
    localparam logic [CNT_W-1:0] HALF_C = CNT_W'(TICKS_PER_SEC / 2);
    localparam logic [CNT_W-1:0] HALF_SYNC_C =
        CNT_W'(TICKS_PER_SEC / 2 - SYNC_TICKS);
    localparam logic [CNT_W-1:0] END_SYNC_C =
        CNT_W'(TICKS_PER_SEC - SYNC_TICKS);

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic ap_wr_q;
    logic rd_pend_q;
    logic [7:0] ap_addr_q;
    logic [DATA_W-1:0] hrdata_q;
    logic [DATA_W-1:0] ctrl_rd;
    logic [DATA_W-1:0] alarm_rd;
    logic [DATA_W-1:0] time_rd;
    logic take;
    logic ctl_wr;
    logic alm_wr;
    logic tim_wr;
    logic tim_acc;

    assign take = hsel & hready & htrans[1];

    // reads stall one cycle so the data reflects any write just before
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ap_wr_q <= 1'b0;
            rd_pend_q <= 1'b0;
            ap_addr_q <= 8'h00;
        end else begin
            ap_wr_q <= take & hwrite;
            rd_pend_q <= take & ~hwrite;
            if (take) begin
                ap_addr_q <= haddr[7:0];
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            hrdata_q <= '0;
        end else if (rd_pend_q) begin
            case (ap_addr_q)
                OFS_RTC_CONTROL: hrdata_q <= ctrl_rd;
                OFS_ALARM_CONTROL: hrdata_q <= alarm_rd;
                OFS_TIME_OF_DAY: hrdata_q <= time_rd;
                default: hrdata_q <= '0;
            endcase
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = ~rd_pend_q;
    assign hresp = 1'b0;
    assign ctl_wr = ap_wr_q & (ap_addr_q == OFS_RTC_CONTROL);
    assign alm_wr = ap_wr_q & (ap_addr_q == OFS_ALARM_CONTROL);
    assign tim_wr = ap_wr_q & (ap_addr_q == OFS_TIME_OF_DAY);

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    logic en_q;
    logic sel_q;
    logic unlock_q;
    logic oe_q;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            en_q <= 1'b0;
            sel_q <= 1'b0;
            unlock_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (ctl_wr) begin
            if (unlock_q) begin
                en_q <= hwdata[CTL_ENABLE_BIT];
            end
            sel_q <= hwdata[CTL_OUT_SEL_BIT];
            oe_q <= hwdata[CTL_OE_BIT];
            // a set only takes under system unlock; clearing always works
            unlock_q <= hwdata[CTL_UNLOCK_BIT]
                        & (sys_unlock | unlock_q);
        end
    end

    assign tim_acc = tim_wr & unlock_q;

    // ----------------------------------------------------------------
    // prescaler: ticks within one second
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cnt_q;
    logic half_roll;
    logic sec_roll;
    logic half_flag;
    logic near_roll;

    assign half_roll = rtc_tick & en_q & (cnt_q == HALF_C - CNT_W'(1));
    assign sec_roll = rtc_tick & en_q & (cnt_q == LAST_C);

    // stops while disabled; an accepted (unlocked) time write restarts the second
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_q <= '0;
        end else if (tim_acc) begin
            cnt_q <= '0;
        end else if (rtc_tick && en_q) begin
            cnt_q <= sec_roll ? '0 : cnt_q + CNT_W'(1);
        end
    end

    assign half_flag = (cnt_q >= HALF_C);
    // within the sync window of either half-second boundary
    assign near_roll = (cnt_q >= HALF_SYNC_C && cnt_q < HALF_C)
                       || (cnt_q >= END_SYNC_C);

    // ----------------------------------------------------------------
    // time of day digits
    // ----------------------------------------------------------------
    rtc_digit_if dig[NUM_DIGITS] ();
    logic [NUM_DIGITS-1:0] inc;
    logic [NUM_DIGITS-1:0] at_max;
    logic [3:0] dval [NUM_DIGITS];
    logic hr_last;

    assign inc[0] = sec_roll;
    assign hr_last = (dval[5] == HOUR_TENS_LAST)
                     && (dval[4] == HOUR_UNITS_LAST);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_DIGITS; gi++) begin : g_dig
            if (gi > 0) begin : g_chain
                assign inc[gi] = inc[gi-1] & at_max[gi-1];
            end
            assign dig[gi].inc = inc[gi];
            // hours wrap 23 -> 00 instead of running on to 29
            assign dig[gi].clr = (gi >= 4) & inc[4] & hr_last;
            assign dig[gi].ld = tim_acc;
            assign dig[gi].ld_val = 4'((hwdata >> DIG_LSB[gi])
                & ((32'h1 << DIG_W[gi]) - 32'h1));
            assign dval[gi] = dig[gi].val;
            assign at_max[gi] = dig[gi].at_max;
            rtc_bcd_digit #(
                .MAX(DIG_MAX[gi])
            ) u_digit (
                .core_clk(core_clk),
                .srst(srst),
                .dig(dig[gi])
            );
        end
    endgenerate

    // time read image, reserved bits zero
    always_comb begin
        time_rd = '0;
        for (int i = 0; i < NUM_DIGITS; i++) begin
            time_rd = time_rd | (DATA_W'(dval[i]) << DIG_LSB[i]);
        end
    end

    // ----------------------------------------------------------------
    // alarm engine
    // ----------------------------------------------------------------
    logic aen_q;
    logic chime_q;
    logic [3:0] mask_q;
    logic [7:0] rpt_q;
    logic pulse_q;
    logic sec_ev_q;
    logic half_ev_q;
    logic [DATA_W-1:0] cmp_mask;
    logic tmatch;
    logic alarm_ev;

    // evaluate one cycle after a boundary, on the already updated time
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sec_ev_q <= 1'b0;
            half_ev_q <= 1'b0;
        end else begin
            sec_ev_q <= sec_roll;
            half_ev_q <= half_roll | sec_roll;
        end
    end

    // fields of the time that must match for each interval
    always_comb begin
        case (mask_q)
            AM_TEN_SEC: cmp_mask = 32'h0000_0f00;
            AM_MIN: cmp_mask = 32'h0000_7f00;
            AM_TEN_MIN: cmp_mask = 32'h000f_7f00;
            AM_HOUR: cmp_mask = 32'h007f_7f00;
            default: cmp_mask = 32'h3f7f_7f00;
        endcase
    end

    assign tmatch = ((time_rd ^ alarm_time) & cmp_mask) == '0;

    // interval selection; reserved codes never fire
    always_comb begin
        case (mask_q)
            AM_HALF_SEC: alarm_ev = half_ev_q;
            AM_SEC: alarm_ev = sec_ev_q;
            AM_TEN_SEC, AM_MIN, AM_TEN_MIN, AM_HOUR, AM_DAY:
                alarm_ev = sec_ev_q & tmatch;
            AM_WEEK: alarm_ev = sec_ev_q & tmatch & wday_match;
            AM_MONTH: alarm_ev = sec_ev_q & tmatch & day_match;
            AM_YEAR: alarm_ev = sec_ev_q & tmatch & day_match & month_match
                                & (~alarm_feb29 | leap_year);
            default: alarm_ev = 1'b0;
        endcase
        alarm_ev = alarm_ev & aen_q & en_q;
    end

    // a hardware event in the same cycle as a write overrides the write
    always_ff @(posedge core_clk) begin
        if (srst) begin
            aen_q <= 1'b0;
            chime_q <= 1'b0;
            mask_q <= 4'h0;
            rpt_q <= 8'h00;
        end else begin
            if (alm_wr) begin
                aen_q <= hwdata[ALM_ENABLE_BIT];
                chime_q <= hwdata[ALM_CHIME_BIT];
                mask_q <= hwdata[ALM_MASK_LSB +: 4];
                rpt_q <= hwdata[ALM_RPT_LSB +: 8];
            end
            if (alarm_ev) begin
                if (rpt_q != 8'h00) begin
                    rpt_q <= rpt_q - 8'h01;
                end else if (chime_q) begin
                    rpt_q <= RPT_WRAP;
                end else begin
                    aen_q <= 1'b0;
                end
            end
        end
    end

    // pulse toggles per event; its start level is set while alarms are off
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pulse_q <= PIV_RST;
        end else if (alarm_ev) begin
            pulse_q <= ~pulse_q;
        end else if (alm_wr && !aen_q) begin
            pulse_q <= hwdata[ALM_PIV_BIT];
        end
    end

    // ----------------------------------------------------------------
    // read images and output pin
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_rd = '0;
        ctrl_rd[CTL_ENABLE_BIT] = en_q;
        ctrl_rd[CTL_OUT_SEL_BIT] = sel_q;
        ctrl_rd[CTL_RUNNING_BIT] = en_q;
        ctrl_rd[CTL_UNLOCK_BIT] = unlock_q;
        ctrl_rd[CTL_RIPPLE_BIT] = near_roll;
        ctrl_rd[CTL_HALF_BIT] = half_flag;
        ctrl_rd[CTL_OE_BIT] = oe_q;
        alarm_rd = '0;
        alarm_rd[ALM_ENABLE_BIT] = aen_q;
        alarm_rd[ALM_CHIME_BIT] = chime_q;
        alarm_rd[ALM_PIV_BIT] = pulse_q;
        alarm_rd[ALM_SYNC_BIT] = near_roll;
        alarm_rd[ALM_MASK_LSB +: 4] = mask_q;
        alarm_rd[ALM_RPT_LSB +: 8] = rpt_q;
    end

    // registered pin; seconds clock is the half-second flag (1 hz square)
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rtc_out <= 1'b0;
        end else begin
            rtc_out <= oe_q & (sel_q ? half_flag : pulse_q);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_UNLOCK_GATED: assert property (
        @(posedge core_clk) disable iff (srst)
        $rose(unlock_q) |-> $past(sys_unlock))
        else $error("unlock set without system unlock");

    AST_ENABLE_LOCKED: assert property (
        @(posedge core_clk) disable iff (srst)
        $changed(en_q) |-> $past(unlock_q) && $past(ctl_wr))
        else $error("module enable changed while locked");

    AST_TIME_LOAD: assert property (
        @(posedge core_clk) disable iff (srst)
        tim_acc |=> time_rd == ($past(hwdata) & 32'h3f7f_7f00))
        else $error("accepted time write not stored");

    AST_TIME_LOCKED: assert property (
        @(posedge core_clk) disable iff (srst)
        (tim_wr && !unlock_q && !sec_roll) |=> $stable(time_rd))
        else $error("locked time write changed time");

    AST_HALF_CLEAR: assert property (
        @(posedge core_clk) disable iff (srst)
        tim_acc |=> !half_flag ##1 !half_flag)
        else $error("half-second flag not cleared by time write");

    AST_OE_GATE: assert property (
        @(posedge core_clk) disable iff (srst)
        !oe_q |=> !rtc_out)
        else $error("pin active with output disabled");

    AST_AUTO_OFF: assert property (
        @(posedge core_clk) disable iff (srst)
        (alarm_ev && rpt_q == 8'h00 && !chime_q) |=> !aen_q && rpt_q == 8'h00)
        else $error("alarm not disabled after last event");

    AST_CHIME_WRAP: assert property (
        @(posedge core_clk) disable iff (srst)
        (alarm_ev && rpt_q == 8'h00 && chime_q) |=> rpt_q == 8'hff && aen_q)
        else $error("repeat count did not wrap with chime");

    AST_RPT_DEC: assert property (
        @(posedge core_clk) disable iff (srst)
        (alarm_ev && rpt_q != 8'h00) |=> rpt_q == $past(rpt_q) - 8'h01)
        else $error("repeat count did not decrement");

    AST_PIV_RO: assert property (
        @(posedge core_clk) disable iff (srst)
        (alm_wr && aen_q && !alarm_ev) |=> pulse_q == $past(pulse_q))
        else $error("pulse value written while alarm enabled");

    AST_SYNC_FAR: assert property (
        @(posedge core_clk) disable iff (srst)
        (en_q && !near_roll && !tim_acc) |-> !half_roll && !sec_roll)
        else $error("sync low at a half-second rollover");

endmodule // rtc_alarm_time_regs

// *** sim/rtc_alarm_time_regs_test.sv ***
// rtc_alarm_time_regs_test: register-level bench for the rtc control,
// alarm and time-of-day block, driven as an ahb-lite master.
// assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
end
module rtc_alarm_time_regs_test;
    import rtc_pkg::*;
    // ----------------------------------------------------------------
    // signals and instance
    // ----------------------------------------------------------------
    localparam int TPS = 128; // short second keeps the run brief
    logic core_clk, srst, hsel, hwrite, hreadyout, hresp, rtc_out;
    logic rtc_tick, sys_unlock, wday_match, day_match, month_match;
    logic alarm_feb29, leap_year;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, alarm_time;
    int mismatches = 0;
    int n_compared = 0;
    rtc_alarm_time_regs #(.TICKS_PER_SEC(TPS), .SYNC_TICKS(4))
        rtc_alarm_time_regs_i (
        .core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rtc_tick(rtc_tick), .sys_unlock(sys_unlock),
        .alarm_time(alarm_time), .wday_match(wday_match),
        .day_match(day_match), .month_match(month_match),
        .alarm_feb29(alarm_feb29), .leap_year(leap_year),
        .rtc_out(rtc_out));
    // ----------------------------------------------------------------
    // bus and timebase tasks
    // ----------------------------------------------------------------
    // address phase held until hready seen high, then data phase
    task automatic bus_wr(input logic [7:0] ofs, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, ofs};
        hwrite <= 1'b1;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
    endtask
    // read data taken at the edge that ends the data phase
    task automatic check_reg(input string nm, input logic [7:0] ofs,
                             input logic [31:0] exp,
                             input logic [31:0] msk = 32'hffff_ffff);
        logic [31:0] d;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, ofs};
        hwrite <= 1'b0;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        d = hrdata & msk;
        `CHK(nm, exp, d)
        `CHK("hresp", 1'b0, hresp)
    endtask
    // n ticks back to back, then room for the alarm pipeline to settle
    task automatic run_ticks(input int n);
        rtc_tick <= 1'b1;
        repeat (n) @(posedge core_clk);
        rtc_tick <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // clock, reset and watchdog
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // far above the roughly 1200 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        wrap_up();
    end
    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] exp_rpt [3];
        exp_rpt = '{32'h8001, 32'h8000, 32'h0000};
        srst = 1'b1; hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; haddr = '0; hwdata = '0; rtc_tick = 1'b0;
        sys_unlock = 1'b0; alarm_time = '0; wday_match = 1'b0;
        day_match = 1'b0; month_match = 1'b0; alarm_feb29 = 1'b0;
        leap_year = 1'b0;
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        `CHK("rtc_out reset", 1'b0, rtc_out)
        check_reg("ctrl reset", OFS_RTC_CONTROL, 32'h0);
        check_reg("alarm reset", OFS_ALARM_CONTROL, 32'h0);
        bus_wr(8'h30, 32'hffff_ffff);
        check_reg("unmapped", 8'h30, 32'h0);
        // locked: unlock, enable and time writes all refused
        bus_wr(OFS_RTC_CONTROL, 32'hffff_ffff);
        check_reg("ctrl locked", OFS_RTC_CONTROL, 32'h81);
        bus_wr(OFS_TIME_OF_DAY, 32'h2359_5800);
        check_reg("time locked", OFS_TIME_OF_DAY, 32'h0);
        sys_unlock <= 1'b1;
        bus_wr(OFS_RTC_CONTROL, 32'h8);
        check_reg("ctrl unlock", OFS_RTC_CONTROL, 32'h8);
        bus_wr(OFS_TIME_OF_DAY, 32'he3d9_d8ff);
        check_reg("time bcd", OFS_TIME_OF_DAY, 32'h2359_5800);
        bus_wr(OFS_RTC_CONTROL, 32'h8089);
        check_reg("ctrl on", OFS_RTC_CONTROL, 32'h80c9);
        // two seconds take 23:59:58 through midnight
        run_ticks(2 * TPS);
        check_reg("midnight", OFS_TIME_OF_DAY, 32'h0);
        check_reg("first half", OFS_RTC_CONTROL, 32'h80c9);
        `CHK("pin low", 1'b0, rtc_out)
        run_ticks(TPS / 2);
        check_reg("second half", OFS_RTC_CONTROL, 32'h80cb);
        `CHK("pin high", 1'b1, rtc_out)
        // two ticks short of the rollover both sync flags must warn
        run_ticks(TPS / 2 - 2);
        check_reg("ripple", OFS_RTC_CONTROL, 32'h80cf);
        check_reg("alarm sync", OFS_ALARM_CONTROL, 32'h1000);
        bus_wr(OFS_TIME_OF_DAY, 32'h0000_3000);
        check_reg("half cleared", OFS_RTC_CONTROL, 32'h80c9);
        bus_wr(OFS_RTC_CONTROL, 32'h8088);
        run_ticks(TPS / 2);
        `CHK("pin gated", 1'b0, rtc_out)
        bus_wr(OFS_RTC_CONTROL, 32'h8);
        // no access in the cycle right after disabling the module
        @(posedge core_clk);
        run_ticks(TPS);
        check_reg("stopped", OFS_TIME_OF_DAY, 32'h0000_3000);
        check_reg("ctrl off", OFS_RTC_CONTROL, 32'h0a);
        bus_wr(OFS_RTC_CONTROL, 32'h8008);
        bus_wr(OFS_TIME_OF_DAY, 32'h0);
        // pulse start level writable only while alarms are off
        bus_wr(OFS_ALARM_CONTROL, 32'hffff_2000);
        check_reg("piv set", OFS_ALARM_CONTROL, 32'h2000);
        bus_wr(OFS_ALARM_CONTROL, 32'h0);
        bus_wr(OFS_ALARM_CONTROL, 32'h8002);
        bus_wr(OFS_ALARM_CONTROL, 32'ha002);
        check_reg("piv locked", OFS_ALARM_CONTROL, 32'h8002);
        // mask 0000 fires each half second; count of 2 gives 3 alarms
        for (int i = 0; i < 3; i++) begin
            run_ticks(TPS / 2);
            check_reg("repeat", OFS_ALARM_CONTROL, exp_rpt[i],
                      32'hffff_dfff);
        end
        run_ticks(TPS / 2);
        check_reg("stays off", OFS_ALARM_CONTROL, 32'h0,
                  32'hffff_dfff);
        // chime lets the count wrap and keeps the alarm on
        bus_wr(OFS_ALARM_CONTROL, 32'hc000);
        run_ticks(TPS / 2);
        check_reg("chime wrap", OFS_ALARM_CONTROL, 32'hc0ff,
                  32'hffff_dfff);
        // prescaler sits mid-second here: the next boundary is a whole
        // second and fires, the one after is mid-second and must not
        bus_wr(OFS_ALARM_CONTROL, 32'h8101);
        run_ticks(TPS / 2);
        check_reg("sec mask", OFS_ALARM_CONTROL, 32'h8100,
                  32'hffff_dfff);
        run_ticks(TPS / 2);
        check_reg("sec mask mid", OFS_ALARM_CONTROL, 32'h8100,
                  32'hffff_dfff);
        wrap_up();
    end
endmodule // rtc_alarm_time_regs_test
